/* File: inc/gpio_port_pkg.sv */
// Constants, register map and types shared by the digital I/O port.
package gpio_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int unsigned PORT_WIDTH_DEFAULT = 8;
  localparam int unsigned AXI_ADDR_WIDTH     = 8;
  localparam int unsigned AXI_DATA_WIDTH     = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] OFS_OUTPUT_VALUE = 8'h00;
  localparam logic [7:0] OFS_DIRECTION    = 8'h04;
  localparam logic [7:0] OFS_INPUT_SAMPLE = 8'h08;
  localparam logic [7:0] OFS_MCU_CONTROL  = 8'h0C;
  localparam logic [7:0] OFS_DIR_SET      = 8'h10;
  localparam logic [7:0] OFS_DIR_CLEAR    = 8'h14;
  localparam logic [7:0] OFS_OUT_SET      = 8'h18;
  localparam logic [7:0] OFS_OUT_CLEAR    = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // Fields and reset values.
  localparam int unsigned CTRL_PULLUP_DISABLE_BIT = 0;
  localparam logic [31:0] OUTPUT_VALUE_RESET      = 32'h0000_0000;
  localparam logic [31:0] DIRECTION_RESET         = 32'h0000_0000;
  localparam logic [31:0] INPUT_SAMPLE_RESET      = 32'h0000_0000;
  localparam logic        PULLUP_DISABLE_RESET    = 1'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers and timing.
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
  localparam int unsigned SYNC_DELAY_CYCLES  = 1;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESPOND = 2'b01
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE    = 2'b00,
    RD_RESPOND = 2'b01
  } rd_state_t;

endpackage

/* File: hdl/pin_input_sync.sv */
// One pin's input synchronizer: a high-transparent latch followed by a rising-edge flop.
`timescale 1ns/1ps
module pin_input_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin_level,
  output logic      pin_input_bit
);

  logic sync_latch;

  // Transparent while the clock is high, holding while it is low.
  always_latch begin
    if (clk) begin
      sync_latch <= pin_level;
    end
  end

  // Only the flop reads the latch, keeping metastability out.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_input_bit <= 1'b0;
    end else begin
      pin_input_bit <= sync_latch;
    end
  end

endmodule // pin_input_sync

/* File: hdl/general_digital_io_port.sv */
// General-purpose digital I/O port with an AXI4-Lite register slave.
`timescale 1ns/1ps
module general_digital_io_port #(
  parameter int unsigned PORT_WIDTH = gpio_port_pkg::PORT_WIDTH_DEFAULT
) (
  input  wire logic                                       clk,
  input  wire logic                                       nrst,
  // AXI4-Lite write address channel.
  input  wire logic                                       s_axi_awvalid,
  output logic                                            s_axi_awready,
  input  wire logic [gpio_port_pkg::AXI_ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                                 s_axi_awprot,
  // AXI4-Lite write data channel.
  input  wire logic                                       s_axi_wvalid,
  output logic                                            s_axi_wready,
  input  wire logic [gpio_port_pkg::AXI_DATA_WIDTH-1:0]   s_axi_wdata,
  input  wire logic [3:0]                                 s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic                                            s_axi_bvalid,
  input  wire logic                                       s_axi_bready,
  output logic [1:0]                                      s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic                                       s_axi_arvalid,
  output logic                                            s_axi_arready,
  input  wire logic [gpio_port_pkg::AXI_ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic [2:0]                                 s_axi_arprot,
  // AXI4-Lite read data channel.
  output logic                                            s_axi_rvalid,
  input  wire logic                                       s_axi_rready,
  output logic [gpio_port_pkg::AXI_DATA_WIDTH-1:0]        s_axi_rdata,
  output logic [1:0]                                      s_axi_rresp,
  // Alternate function overrides, one bit per pin.
  input  wire logic [PORT_WIDTH-1:0]                      alt_enable,
  input  wire logic [PORT_WIDTH-1:0]                      alt_drive_enable,
  input  wire logic [PORT_WIDTH-1:0]                      alt_drive_value,
  input  wire logic [PORT_WIDTH-1:0]                      alt_pullup_enable,
  // Pads.
  input  wire logic [PORT_WIDTH-1:0]                      pin_in,
  output logic [PORT_WIDTH-1:0]                           pin_out,
  output logic [PORT_WIDTH-1:0]                           pin_oe,
  output logic [PORT_WIDTH-1:0]                           pin_pullup_en
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter check.

  if (PORT_WIDTH < 1 || PORT_WIDTH > gpio_port_pkg::AXI_DATA_WIDTH) begin : g_width_check
    $error("PORT_WIDTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam int unsigned AW = gpio_port_pkg::AXI_ADDR_WIDTH;
  localparam int unsigned DW = gpio_port_pkg::AXI_DATA_WIDTH;

  logic [PORT_WIDTH-1:0]  pin_output_value_reg;
  logic [PORT_WIDTH-1:0]  pin_output_value_next;
  logic [PORT_WIDTH-1:0]  pin_direction_reg;
  logic [PORT_WIDTH-1:0]  pin_direction_next;
  logic [PORT_WIDTH-1:0]  pin_input_sample_reg;
  logic                   global_pullup_disable_reg;
  logic                   global_pullup_disable_next;

  gpio_port_pkg::wr_state_t wr_state_reg;
  gpio_port_pkg::rd_state_t rd_state_reg;

  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [AW-1:0]          wr_addr_reg;
  logic [DW-1:0]          wr_data_reg;
  logic [3:0]             wr_strb_reg;
  logic [1:0]             bresp_reg;
  logic [DW-1:0]          rdata_reg;
  logic [1:0]             rresp_reg;

  logic                   wr_fire;
  logic                   wr_lane0;
  logic                   wr_mapped;
  logic [PORT_WIDTH-1:0]  wr_bits;
  logic                   rd_fire;
  logic [DW-1:0]          rd_value;
  logic                   rd_mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronizers, one per pin.

  for (genvar n = 0; n < PORT_WIDTH; n++) begin : g_sync
    pin_input_sync u_sync (
      .clk           (clk),
      .nrst          (nrst),
      .pin_level     (pin_in[n]),
      .pin_input_bit (pin_input_sample_reg[n])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad control.

  // Pads with alt_enable low are gated straight from register bits, so reset
  // frees them with no clock edge; alt_enable pads follow the alt inputs, but the global disable still masks their pull-up.
  always_comb begin
    for (int n = 0; n < PORT_WIDTH; n++) begin
      if (alt_enable[n]) begin
        pin_oe[n]        = alt_drive_enable[n];
        pin_out[n]       = alt_drive_value[n];
        pin_pullup_en[n] = alt_pullup_enable[n] & ~global_pullup_disable_reg;
      end else begin
        pin_oe[n]        = pin_direction_reg[n];
        pin_out[n]       = pin_output_value_reg[n] & pin_direction_reg[n];
        pin_pullup_en[n] = ~pin_direction_reg[n] & pin_output_value_reg[n]
                         & ~global_pullup_disable_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = (wr_state_reg == gpio_port_pkg::WR_RESPOND);
  assign s_axi_bresp   = bresp_reg;

  assign wr_fire  = aw_held_reg & w_held_reg & (wr_state_reg == gpio_port_pkg::WR_COLLECT);
  assign wr_lane0 = wr_strb_reg[0];
  assign wr_bits  = wr_data_reg[PORT_WIDTH-1:0];

  always_comb begin
    case (wr_addr_reg[7:2])
      gpio_port_pkg::OFS_OUTPUT_VALUE[7:2],
      gpio_port_pkg::OFS_DIRECTION[7:2],
      gpio_port_pkg::OFS_INPUT_SAMPLE[7:2],
      gpio_port_pkg::OFS_MCU_CONTROL[7:2],
      gpio_port_pkg::OFS_DIR_SET[7:2],
      gpio_port_pkg::OFS_DIR_CLEAR[7:2],
      gpio_port_pkg::OFS_OUT_SET[7:2],
      gpio_port_pkg::OFS_OUT_CLEAR[7:2]: begin
        wr_mapped = 1'b1;
      end
      default: begin
        wr_mapped = 1'b0;
      end
    endcase
  end

  // Address and data are caught apart, so either may come first.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      wr_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_held_reg  <= 1'b0;
      wr_data_reg <= '0;
      wr_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg  <= 1'b1;
      wr_data_reg <= s_axi_wdata;
      wr_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_state_reg <= gpio_port_pkg::WR_COLLECT;
      bresp_reg    <= gpio_port_pkg::RESP_OKAY;
    end else begin
      case (wr_state_reg)
        gpio_port_pkg::WR_COLLECT: begin
          if (wr_fire) begin
            wr_state_reg <= gpio_port_pkg::WR_RESPOND;
            bresp_reg    <= wr_mapped ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
          end
        end
        gpio_port_pkg::WR_RESPOND: begin
          if (s_axi_bready) begin
            wr_state_reg <= gpio_port_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_reg <= gpio_port_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register updates.

  // Any nonzero strobe writes every pin bit, keeping wide ports whole;
  // only the control bit insists on lane 0.
  always_comb begin
    pin_output_value_next      = pin_output_value_reg;
    pin_direction_next         = pin_direction_reg;
    global_pullup_disable_next = global_pullup_disable_reg;
    if (wr_fire && wr_strb_reg != 4'h0) begin
      case (wr_addr_reg[7:2])
        gpio_port_pkg::OFS_OUTPUT_VALUE[7:2]: begin
          pin_output_value_next = wr_bits;
        end
        gpio_port_pkg::OFS_DIRECTION[7:2]: begin
          pin_direction_next = wr_bits;
        end
        gpio_port_pkg::OFS_INPUT_SAMPLE[7:2]: begin
          // Ones toggle, zeros keep the bit, whatever the direction.
          pin_output_value_next = pin_output_value_reg ^ wr_bits;
        end
        gpio_port_pkg::OFS_MCU_CONTROL[7:2]: begin
          if (wr_lane0) begin
            global_pullup_disable_next =
              wr_data_reg[gpio_port_pkg::CTRL_PULLUP_DISABLE_BIT];
          end
        end
        gpio_port_pkg::OFS_DIR_SET[7:2]: begin
          pin_direction_next = pin_direction_reg | wr_bits;
        end
        gpio_port_pkg::OFS_DIR_CLEAR[7:2]: begin
          pin_direction_next = pin_direction_reg & ~wr_bits;
        end
        gpio_port_pkg::OFS_OUT_SET[7:2]: begin
          pin_output_value_next = pin_output_value_reg | wr_bits;
        end
        gpio_port_pkg::OFS_OUT_CLEAR[7:2]: begin
          pin_output_value_next = pin_output_value_reg & ~wr_bits;
        end
        default: begin
          pin_output_value_next = pin_output_value_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_output_value_reg <= gpio_port_pkg::OUTPUT_VALUE_RESET[PORT_WIDTH-1:0];
    end else begin
      pin_output_value_reg <= pin_output_value_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_direction_reg <= gpio_port_pkg::DIRECTION_RESET[PORT_WIDTH-1:0];
    end else begin
      pin_direction_reg <= pin_direction_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_pullup_disable_reg <= gpio_port_pkg::PULLUP_DISABLE_RESET;
    end else begin
      global_pullup_disable_reg <= global_pullup_disable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  assign s_axi_arready = (rd_state_reg == gpio_port_pkg::RD_IDLE);
  assign s_axi_rvalid  = (rd_state_reg == gpio_port_pkg::RD_RESPOND);
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_value  = '0;
    rd_mapped = 1'b1;
    case (s_axi_araddr[7:2])
      gpio_port_pkg::OFS_OUTPUT_VALUE[7:2],
      gpio_port_pkg::OFS_OUT_SET[7:2],
      gpio_port_pkg::OFS_OUT_CLEAR[7:2]: begin
        rd_value[PORT_WIDTH-1:0] = pin_output_value_reg;
      end
      gpio_port_pkg::OFS_DIRECTION[7:2],
      gpio_port_pkg::OFS_DIR_SET[7:2],
      gpio_port_pkg::OFS_DIR_CLEAR[7:2]: begin
        rd_value[PORT_WIDTH-1:0] = pin_direction_reg;
      end
      gpio_port_pkg::OFS_INPUT_SAMPLE[7:2]: begin
        // The sample lags the pad, so a
        // written level reads back one cycle late.
        rd_value[PORT_WIDTH-1:0] = pin_input_sample_reg;
      end
      gpio_port_pkg::OFS_MCU_CONTROL[7:2]: begin
        rd_value[gpio_port_pkg::CTRL_PULLUP_DISABLE_BIT] = global_pullup_disable_reg;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_state_reg <= gpio_port_pkg::RD_IDLE;
      rdata_reg    <= '0;
      rresp_reg    <= gpio_port_pkg::RESP_OKAY;
    end else begin
      case (rd_state_reg)
        gpio_port_pkg::RD_IDLE: begin
          if (rd_fire) begin
            rd_state_reg <= gpio_port_pkg::RD_RESPOND;
            rdata_reg    <= rd_value;
            rresp_reg    <= rd_mapped ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
          end
        end
        gpio_port_pkg::RD_RESPOND: begin
          if (s_axi_rready) begin
            rd_state_reg <= gpio_port_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= gpio_port_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Protection bits are ignored: any privilege may reach the port.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule // general_digital_io_port

/* File: testbench/gpio_port_checker.sv */
// Concurrent checks on the ports of the digital I/O port.
`timescale 1ns/1ps
module gpio_port_checker #(
  parameter int unsigned PORT_WIDTH = 8
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [7:0]            s_axi_awaddr,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_bvalid,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_rvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic [PORT_WIDTH-1:0] alt_enable,
  input wire logic [PORT_WIDTH-1:0] pin_in,
  input wire logic [PORT_WIDTH-1:0] pin_out,
  input wire logic [PORT_WIDTH-1:0] pin_oe,
  input wire logic [PORT_WIDTH-1:0] pin_pullup_en
);
  logic                  wr_take;
  logic                  ar_take;
  logic                  pend_q;
  logic [7:0]            aw_q;
  logic [31:0]           wd_q;
  logic [3:0]            st_q;
  logic [PORT_WIDTH-1:0] out_sh;
  logic [PORT_WIDTH-1:0] dir_sh;
  logic                  pud_sh;
  logic [31:0]           rd_exp;

  // The bench offers address and data together, so one joint handshake is tracked.
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      aw_q   <= '0;
      wd_q   <= '0;
      st_q   <= '0;
    end else begin
      pend_q <= wr_take;
      if (wr_take) begin
        aw_q <= s_axi_awaddr;
        wd_q <= s_axi_wdata;
        st_q <= s_axi_wstrb;
      end
    end
  end

  // Shadows update on the port's own write edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_sh <= '0;
      dir_sh <= '0;
      pud_sh <= 1'b0;
    end else if (pend_q && st_q != 4'h0) begin
      case (aw_q)
        gpio_port_pkg::OFS_OUTPUT_VALUE: out_sh <= wd_q[PORT_WIDTH-1:0];
        gpio_port_pkg::OFS_DIRECTION:    dir_sh <= wd_q[PORT_WIDTH-1:0];
        gpio_port_pkg::OFS_INPUT_SAMPLE: out_sh <= out_sh ^ wd_q[PORT_WIDTH-1:0];
        gpio_port_pkg::OFS_MCU_CONTROL:  if (st_q[0]) pud_sh <= wd_q[0];
        gpio_port_pkg::OFS_DIR_SET:      dir_sh <= dir_sh | wd_q[PORT_WIDTH-1:0];
        gpio_port_pkg::OFS_DIR_CLEAR:    dir_sh <= dir_sh & ~wd_q[PORT_WIDTH-1:0];
        gpio_port_pkg::OFS_OUT_SET:      out_sh <= out_sh | wd_q[PORT_WIDTH-1:0];
        gpio_port_pkg::OFS_OUT_CLEAR:    out_sh <= out_sh & ~wd_q[PORT_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_exp = '0;
    case (s_axi_araddr)
      gpio_port_pkg::OFS_OUTPUT_VALUE, gpio_port_pkg::OFS_OUT_SET,
      gpio_port_pkg::OFS_OUT_CLEAR: rd_exp = 32'(out_sh);
      gpio_port_pkg::OFS_DIRECTION, gpio_port_pkg::OFS_DIR_SET,
      gpio_port_pkg::OFS_DIR_CLEAR: rd_exp = 32'(dir_sh);
      gpio_port_pkg::OFS_MCU_CONTROL: rd_exp = 32'(pud_sh);
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_wr_taken;
    wr_take;
  endsequence
  sequence s_b_answer;
    !s_axi_bvalid ##1 (s_axi_bvalid && s_axi_bresp == ((aw_q <= gpio_port_pkg::OFS_OUT_CLEAR)
      ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR));
  endsequence
  sequence s_toggle_write;
    wr_take && s_axi_awaddr == gpio_port_pkg::OFS_INPUT_SAMPLE && s_axi_wstrb != 4'h0;
  endsequence

  property p_reset_tristate;
    disable iff (1'b0) !nrst |-> (pin_oe == '0 && pin_pullup_en == '0);
  endproperty
  property p_direction;
    (pin_oe & ~alt_enable) == (dir_sh & ~alt_enable);
  endproperty
  property p_drive;
    (pin_out & ~alt_enable) == (out_sh & dir_sh & ~alt_enable);
  endproperty
  property p_pullup;
    (pin_pullup_en & ~alt_enable) == (~dir_sh & out_sh & ~{PORT_WIDTH{pud_sh}} & ~alt_enable);
  endproperty
  property p_global_disable;
    pud_sh |-> pin_pullup_en == '0;
  endproperty
  property p_toggle;
    s_toggle_write ##0 (pin_oe == '1 && alt_enable == '0)
      |-> ##2 pin_out == ($past(pin_out, 2) ^ wd_q[PORT_WIDTH-1:0]);
  endproperty
  property p_write_answer;
    s_wr_taken |-> ##1 s_b_answer;
  endproperty
  property p_read_answer;
    (ar_take && s_axi_araddr != gpio_port_pkg::OFS_INPUT_SAMPLE) |-> ##1 (s_axi_rvalid
      && s_axi_rdata == $past(rd_exp) && s_axi_rresp == (($past(s_axi_araddr) <=
      gpio_port_pkg::OFS_OUT_CLEAR) ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR));
  endproperty
  property p_sample;
    (ar_take && s_axi_araddr == gpio_port_pkg::OFS_INPUT_SAMPLE && $past(nrst, 2)
      && $stable(pin_in) && pin_in == $past(pin_in, 2)) |-> ##1 s_axi_rdata == 32'($past(pin_in));
  endproperty

  a_reset_tristate: assert property (p_reset_tristate) else $error("pins active in reset");
  a_direction: assert property (p_direction) else $error("enable differs");
  a_drive: assert property (p_drive) else $error("driven level differs");
  a_pullup: assert property (p_pullup) else $error("pull-up differs");
  a_global_disable: assert property (p_global_disable) else $error("pull-up on");
  a_toggle: assert property (p_toggle) else $error("toggle wrong");
  a_write_answer: assert property (p_write_answer) else $error("write answer wrong");
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
  a_sample: assert property (p_sample) else $error("sampled level wrong");
endmodule // gpio_port_checker

/* File: testbench/pin_pad_model.sv */
// Pad model: resolves each pin from the port, an outside driver and the pull-up.
`timescale 1ns/1ps
module pin_pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad
);
  // A floating pin wanders so that no stale level passes a check.
  logic [7:0] float_q = 8'h5a;

  always_ff @(posedge clk) float_q <= ~float_q;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup_en[i] | float_q[i];
    end
  end
endmodule // pin_pad_model

/* File: testbench/test_general_digital_io_port.sv */
// Self-checking bench for the digital I/O port.
`timescale 1ns/1ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_general_digital_io_port;
  logic        clk = 1'b0, nrst = 1'b0, clk_run = 1'b1, pud_m = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  prot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, out_m = 8'h00, dir_m = 8'h00;
  logic [7:0]  alt_enable = 8'h00, alt_drive_enable = 8'h00, alt_drive_value = 8'h00;
  logic [7:0]  alt_pullup_enable = 8'h00, ext_en = 8'h00, ext_val = 8'h00, pad;
  logic [7:0]  pin_out, pin_oe, pin_pullup_en, addr_tab [9];
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seed = 32'h0000_77ac;
  int          n_errors = 0, checks_done = 0;

  general_digital_io_port DUT (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(prot), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(prot), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .alt_enable,
    .alt_drive_enable, .alt_drive_value, .alt_pullup_enable, .pin_in(pad), .pin_out, .pin_oe,
    .pin_pullup_en);
  pin_pad_model u_pad (.clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pad);

  initial forever begin
    #2.5;
    if (clk_run) clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [1:0] resp_of(int i);
    return (i == 8) ? gpio_port_pkg::RESP_SLVERR : gpio_port_pkg::RESP_OKAY;
  endfunction

  function automatic logic [31:0] read_of(int i);
    case (i)
      0, 6, 7: return {24'h00_0000, out_m};
      1, 4, 5: return {24'h00_0000, dir_m};
      2:       return {24'h00_0000, (dir_m & out_m) | (~dir_m & ext_val)};
      3:       return {31'h0000_0000, pud_m};
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic void model_wr(int i, logic [31:0] d, logic [3:0] s);
    if (s != 4'h0) begin
      case (i)
        0: out_m = d[7:0];
        1: dir_m = d[7:0];
        2: out_m ^= d[7:0];
        3: if (s[0]) pud_m = d[0];
        4: dir_m |= d[7:0];
        5: dir_m &= ~d[7:0];
        6: out_m |= d[7:0];
        7: out_m &= ~d[7:0];
        default: ;
      endcase
    end
  endfunction

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Answers are read on the falling edge, where they have settled.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic [1:0] rs);
    logic pa, pw, done;
    done = 1'b0;
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
    for (int n = 0; !done; n++) begin
      @(negedge clk);
      pa = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      pw = s_axi_wvalid && s_axi_wready;
      done = wr ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (pa) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (pw) s_axi_wvalid <= 1'b0;
      if (done) {s_axi_bready, s_axi_rready} <= 2'b00;
      if (n > 100) begin
        n_errors++;
        stop_test();
      end
    end
  endtask

  task automatic step(input logic wr, input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(wr, addr_tab[i], d, s, rd, rs);
    if (wr) model_wr(i, d, s);
    else `CHECK(rd, read_of(i))
    `CHECK(rs, resp_of(i))
    @(negedge clk);
    `CHECK(pin_oe & ~alt_enable, dir_m & ~alt_enable)
    `CHECK(pin_out & ~alt_enable, out_m & dir_m & ~alt_enable)
    `CHECK(pin_pullup_en & ~alt_enable, ~dir_m & out_m & ~{8{pud_m}} & ~alt_enable)
    `CHECK(pin_pullup_en & {8{pud_m}}, 8'h00)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int          j;
    addr_tab = '{gpio_port_pkg::OFS_OUTPUT_VALUE, gpio_port_pkg::OFS_DIRECTION,
      gpio_port_pkg::OFS_INPUT_SAMPLE, gpio_port_pkg::OFS_MCU_CONTROL, gpio_port_pkg::OFS_DIR_SET,
      gpio_port_pkg::OFS_DIR_CLEAR, gpio_port_pkg::OFS_OUT_SET, gpio_port_pkg::OFS_OUT_CLEAR, 8'h20};
    repeat (8) @(posedge clk);
    `CHECK(pin_oe | pin_pullup_en, 8'h00)
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) if (i != 2) step(1'b0, i, 32'h0000_0000, 4'h0);
    step(1'b1, 1, 32'h0000_00ff, 4'hf);
    step(1'b1, 0, 32'h0000_003c, 4'h2);
    step(1'b1, 2, 32'h0000_00a5, 4'h8);
    step(1'b1, 2, 32'h0000_0000, 4'hf);
    for (int i = 4; i < 9; i++) step(1'b1, i, 32'h0000_0001 << i, 4'hf);
    step(1'b1, 0, 32'h0000_00ff, 4'h0);
    step(1'b1, 1, 32'h0000_0000, 4'hf);
    step(1'b1, 3, 32'h0000_0001, 4'h2);
    step(1'b1, 3, 32'h0000_0001, 4'h1);
    step(1'b1, 3, 32'h0000_0000, 4'h1);
    // A write moves direction or output, never both, so pins pass a middle state.
    for (int k = 0; k < 80; k++) begin
      r = rnd();
      @(posedge clk);
      alt_enable <= r[31:24] & r[23:16];
      alt_drive_enable <= r[15:8];
      alt_drive_value <= r[7:0];
      alt_pullup_enable <= r[19:12];
      r = rnd();
      j = r[31:28] % 9;
      step(r[12] || j == 2, j, rnd(), r[7:4]);
    end
    alt_enable <= 8'h00;
    for (int k = 0; k < 12; k++) begin
      step(1'b1, 1, rnd(), 4'hf);
      step(1'b1, 0, rnd(), 4'hf);
      @(posedge clk);
      ext_en <= ~dir_m;
      ext_val <= rnd();
      @(posedge clk);
      step(1'b0, 2, 32'h0000_0000, 4'h0);
    end
    step(1'b1, 1, 32'h0000_000f, 4'hf);
    @(negedge clk);
    clk_run = 1'b0;
    nrst = 1'b0;
    #3;
    `CHECK(pin_oe | pin_pullup_en | pin_out, 8'h00)
    clk_run = 1'b1;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    out_m = 8'h00;
    dir_m = 8'h00;
    pud_m = 1'b0;
    for (int i = 0; i < 4; i++) if (i != 2) step(1'b0, i, 32'h0000_0000, 4'h0);
    stop_test();
  end
endmodule // test_general_digital_io_port

bind general_digital_io_port gpio_port_checker #(.PORT_WIDTH(PORT_WIDTH)) u_chk (.clk, .nrst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .alt_enable, .pin_in, .pin_out, .pin_oe,
  .pin_pullup_en);
